/* File: rtl/sram_array.sv */
// Storage array with per-lane write and registered-free read port
`timescale 1ns/100ps
module sram_array #(
    parameter int LANES     = sram_port_pkg::LANES,
    parameter int LANE_BITS = sram_port_pkg::LANE_BITS,
    parameter int ADDR_BITS = sram_port_pkg::ADDR_BITS
) (
    input  wire logic                 mclk_in,
    input  wire logic                 wr_en_in,
    input  wire logic [LANES-1:0]     lane_en_in,
    input  wire logic [ADDR_BITS-1:0] wr_addr_in,
    input  wire sram_port_pkg::word_t wr_word_in,
    input  wire logic [ADDR_BITS-1:0] rd_addr_in,
    output sram_port_pkg::word_t      rd_word_out
);
    logic [LANE_BITS:0] mem [LANES][2**ADDR_BITS];

    // ************************************************************
    // One lane per generate slice: data byte plus its parity bit
    // ************************************************************
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        // Self-timed write from the clocked command alone
        always_ff @(posedge mclk_in)
        begin
            if (wr_en_in && lane_en_in[l])
                mem[l][wr_addr_in] <= {wr_word_in.parity[l], wr_word_in.data[l*LANE_BITS +: LANE_BITS]}; // R6
        end
        assign rd_word_out.data[l*LANE_BITS +: LANE_BITS] = mem[l][rd_addr_in][LANE_BITS-1:0];
        assign rd_word_out.parity[l]                       = mem[l][rd_addr_in][LANE_BITS];
    end
endmodule : sram_array

/* File: rtl/sram_port.sv */
// Synchronous host port of a pipelined burst static RAM
`timescale 1ns/100ps
module sram_port #(
    parameter int LANES     = sram_port_pkg::LANES,
    parameter int LANE_BITS = sram_port_pkg::LANE_BITS,
    parameter int ADDR_BITS = sram_port_pkg::ADDR_BITS
) (
    input  wire logic                       mclk_in,
    input  wire logic                       rst_in,
    input  wire logic                       clock_qualify_n_in,
    input  wire logic                       chip_select_first_n_in,
    input  wire logic                       chip_select_second_in,
    input  wire logic                       chip_select_third_n_in,
    input  wire logic                       write_n_in,
    input  wire logic [LANES-1:0]           byte_lane_select_n_in,
    input  wire logic                       burst_advance_or_load_in,
    input  wire logic [ADDR_BITS-1:0]       addr_in,
    input  wire logic                       burst_order_strap_in,
    input  wire logic                       sleep_request_in,
    input  wire logic                       output_enable_n_in,
    input  wire logic [LANES*LANE_BITS-1:0] data_lane_in,
    input  wire logic [LANES-1:0]           parity_lane_in,
    output logic      [LANES*LANE_BITS-1:0] data_lane_out,
    output logic      [LANES-1:0]           parity_lane_out,
    output logic                            data_lane_oe_n_out,
    output logic                            sleeping_out
);
    localparam int BB = sram_port_pkg::BURST_BITS;

    // ************************************************************
    // Input registers
    // ************************************************************
    logic                 qual_n_reg,   qual_n_next;
    logic                 cs1_n_reg,    cs1_n_next;
    logic                 cs2_reg,      cs2_next;
    logic                 cs3_n_reg,    cs3_n_next;
    logic                 wr_n_reg,     wr_n_next;
    logic [LANES-1:0]     bls_n_reg,    bls_n_next;
    logic                 adv_reg,      adv_next;
    logic [ADDR_BITS-1:0] addr_reg,     addr_next;
    logic                 strap_reg,    strap_next;
    logic                 sleep_reg,    sleep_next;
    logic                 oe_n_meta_reg, oe_n_meta_next;
    logic                 oe_n_reg,     oe_n_next;
    sram_port_pkg::word_t din_reg,      din_next;

    // Every synchronous pin captured once on the rising edge
    always_comb
    begin
        qual_n_next    = clock_qualify_n_in;       // R1
        cs1_n_next     = chip_select_first_n_in;
        cs2_next       = chip_select_second_in;
        cs3_n_next     = chip_select_third_n_in;
        wr_n_next      = write_n_in;
        bls_n_next     = byte_lane_select_n_in;
        adv_next       = burst_advance_or_load_in;
        addr_next      = addr_in;
        strap_next     = burst_order_strap_in;
        sleep_next     = sleep_request_in;
        oe_n_meta_next = output_enable_n_in;
        oe_n_next      = oe_n_meta_reg;
        din_next       = '{data: data_lane_in, parity: parity_lane_in};
    end

    // Asynchronous output enable is resynchronised, two flops
    always_ff @(posedge mclk_in)
    begin
        qual_n_reg    <= qual_n_next;
        cs1_n_reg     <= cs1_n_next;
        cs2_reg       <= cs2_next;
        cs3_n_reg     <= cs3_n_next;
        wr_n_reg      <= wr_n_next;
        bls_n_reg     <= bls_n_next;
        adv_reg       <= adv_next;
        addr_reg      <= addr_next;
        strap_reg     <= strap_next;
        sleep_reg     <= sleep_next;
        oe_n_meta_reg <= oe_n_meta_next;
        oe_n_reg      <= oe_n_next;
        din_reg       <= din_next;
    end

    // ************************************************************
    // Command decode and burst address
    // ************************************************************
    logic                 enabled;
    logic                 selected;
    logic                 linear_mode;
    sram_port_pkg::cmd_t  new_cmd;
    logic [ADDR_BITS-1:0] base_reg,  base_next;
    logic [BB-1:0]        count_reg, count_next;
    logic [BB-1:0]        offset;
    logic                 burst_w_reg, burst_w_next;
    logic                 burst_v_reg, burst_v_next;

    // Clock qualifier and sleep both stall the port
    assign enabled     = !qual_n_reg && !sleep_reg; // R3 R12
    assign selected    = !cs1_n_reg && cs2_reg && !cs3_n_reg; // R7
    assign linear_mode = !strap_reg; // R11

    // Burst offset: linear adds, interleaved xors
    always_comb
    begin
        if (linear_mode)
            offset = base_reg[BB-1:0] + count_next; // R10
        else
            offset = base_reg[BB-1:0] ^ count_next; // R10
    end

    // Load takes a fresh command, advance steps the burst
    always_comb
    begin
        base_next    = base_reg;
        count_next   = count_reg;
        burst_w_next = burst_w_reg;
        burst_v_next = burst_v_reg;
        new_cmd      = '0;
        if (enabled)
        begin
            if (adv_reg)
            begin
                count_next      = count_reg + 1'b1; // R14
                new_cmd.valid   = burst_v_reg;
                new_cmd.write   = burst_w_reg;
                new_cmd.addr    = {base_reg[ADDR_BITS-1:BB], offset};
                new_cmd.lane_en = ~bls_n_reg;
            end
            else
            begin
                base_next       = addr_reg; // R14
                count_next      = sram_port_pkg::BURST_RESET;
                burst_w_next    = !wr_n_reg;
                burst_v_next    = selected;
                new_cmd.valid   = selected; // R4
                new_cmd.write   = !wr_n_reg; // R5
                new_cmd.addr    = addr_reg;
                new_cmd.lane_en = ~bls_n_reg; // R5
            end
        end
    end

    // ************************************************************
    // Two-stage command pipeline
    // ************************************************************
    sram_port_pkg::cmd_t pipe_reg [sram_port_pkg::PIPE_DEPTH];
    sram_port_pkg::cmd_t pipe_next [sram_port_pkg::PIPE_DEPTH];

    // Shift only on enabled edges so latency counts enabled edges
    always_comb
    begin
        pipe_next = pipe_reg;
        if (enabled)
        begin
            pipe_next[0] = new_cmd; // R13
            pipe_next[1] = pipe_reg[0]; // R13
        end
        if (rst_in)
        begin
            pipe_next[0] = '0;
            pipe_next[1] = '0;
        end
    end

    // Burst state, reset only for the controlled part
    always_ff @(posedge mclk_in)
    begin
        pipe_reg    <= pipe_next; // R3
        base_reg    <= rst_in ? '0 : base_next;
        count_reg   <= rst_in ? sram_port_pkg::BURST_RESET : count_next;
        burst_w_reg <= rst_in ? 1'b0 : burst_w_next;
        burst_v_reg <= rst_in ? 1'b0 : burst_v_next;
    end

    // ************************************************************
    // Array and data phase
    // ************************************************************
    sram_port_pkg::cmd_t  phase;
    sram_port_pkg::word_t rd_word;
    logic                 do_write;

    assign phase    = pipe_reg[1];
    // Write data sampled at the edge two enabled edges on
    assign do_write = enabled && phase.valid && phase.write; // R13

    sram_array #(
        .LANES     (LANES),
        .LANE_BITS (LANE_BITS),
        .ADDR_BITS (ADDR_BITS)
    ) u_array (
        .mclk_in    (mclk_in),
        .wr_en_in   (do_write),
        .lane_en_in (phase.lane_en),
        .wr_addr_in (phase.addr),
        .wr_word_in (din_reg),
        .rd_addr_in (pipe_reg[0].addr),
        .rd_word_out(rd_word)
    );

    // ************************************************************
    // Output registers
    // ************************************************************
    sram_port_pkg::word_t dout_reg, dout_next;
    logic                 drive_reg, drive_next;
    logic                 slp_reg,   slp_next;

    // Drive only for a read data phase; write phase releases bus
    always_comb
    begin
        dout_next  = dout_reg;
        drive_next = drive_reg;
        if (enabled)
        begin
            dout_next  = rd_word; // R2
            drive_next = pipe_reg[0].valid && !pipe_reg[0].write; // R8 R9
            // Write landing on this edge wins, else back-to-back traffic reads stale data
            if (do_write && phase.addr == pipe_reg[0].addr)
                for (int l = 0; l < LANES; l++)
                    if (phase.lane_en[l])
                    begin
                        dout_next.data[l*LANE_BITS +: LANE_BITS] = din_reg.data[l*LANE_BITS +: LANE_BITS]; // R4
                        dout_next.parity[l]                       = din_reg.parity[l];
                    end
        end
        if (rst_in)
            drive_next = 1'b0;
        slp_next = rst_in ? 1'b0 : sleep_reg; // R12
    end

    always_ff @(posedge mclk_in)
    begin
        dout_reg  <= dout_next;
        drive_reg <= drive_next;
        slp_reg   <= slp_next;
    end

    // Output enable: asynchronous pin gated here after resync
    logic oe_gate_reg;
    always_ff @(posedge mclk_in)
        oe_gate_reg <= rst_in ? 1'b1 : !(drive_next && !oe_n_reg); // R7
    assign data_lane_out      = dout_reg.data;
    assign parity_lane_out    = dout_reg.parity;
    assign data_lane_oe_n_out = oe_gate_reg;
    assign sleeping_out       = slp_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_read_drive_latency: assert property ( // R13
        enabled && new_cmd.valid && !new_cmd.write ##1 enabled && !oe_n_reg ##0 $stable(oe_n_reg)
        |=> !data_lane_oe_n_out)
        else $error("read data not driven two edges after command");
    a_write_release: assert property ( // R8
        enabled && new_cmd.valid && new_cmd.write ##1 enabled |=> data_lane_oe_n_out)
        else $error("drivers active in write data phase");
    a_stall_freeze: assert property ( // R3
        !enabled |=> $stable(pipe_reg[1]) && $stable(count_reg))
        else $error("pipeline moved on stalled edge");
    a_select_gate: assert property ( // R7
        enabled && !adv_reg && !selected |=> !pipe_reg[0].valid)
        else $error("unselected command accepted");
    a_burst_count: assert property ( // R14
        enabled && adv_reg |=> count_reg == $past(count_reg) + 2'h1)
        else $error("burst did not advance");
    a_burst_load: assert property ( // R14
        enabled && !adv_reg |=> count_reg == sram_port_pkg::BURST_RESET && base_reg == $past(addr_reg))
        else $error("load did not capture address");
    a_write_strobe: assert property ( // R5
        enabled && !adv_reg && selected |=> pipe_reg[0].write == !$past(wr_n_reg))
        else $error("write strobe misdecoded");
    a_sleep_flag: assert property ( // R12
        sleep_reg |=> sleeping_out)
        else $error("sleep not reported");
    a_order_linear: assert property ( // R10 R11
        enabled && adv_reg && !strap_reg |=> pipe_reg[0].addr[BB-1:0] == $past(base_reg[BB-1:0] + count_reg + 2'h1))
        else $error("linear order wrong");

    c_read: cover property (enabled && new_cmd.valid && !new_cmd.write);
    c_write: cover property (enabled && new_cmd.valid && new_cmd.write);
    c_stall: cover property (!enabled && pipe_reg[0].valid);
    c_burst: cover property (enabled && adv_reg && burst_v_reg && strap_reg);
endmodule : sram_port

/* File: rtl/sram_port_pkg.sv */
// Constants and carrier types of the pipelined burst static RAM port
// Behaviour
// R1: All synchronous inputs registered on rising edge
// R2: Read data and parity launched from registers
// R3: Deasserted clock qualifier freezes all pipeline state
// R4: New read or write every enabled cycle
// R5: Write strobe plus active-low per-byte lane selects
// R6: Writes complete internally, self-timed, no pulse
// R7: Select needs all three chip selects; async output enable
// R8: Data drivers released during write data phase
// R9: Output enabling managed internally, self-timed
// R10: Bursts follow linear or interleaved address order
// R11: Strap low linear, strap high interleaved
// R12: Sleep input idles port; state preserved
// R13: Read data and write data two enabled edges later
// R14: Advance continues burst, load takes new command
package sram_port_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int LANES      = 4;
    localparam int LANE_BITS  = 8;
    localparam int ADDR_BITS  = 8;
    localparam int BURST_BITS = 2;
    localparam int PIPE_DEPTH = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [BURST_BITS-1:0] BURST_RESET = 2'h0;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic                 valid;
        logic                 write;
        logic [LANES-1:0]     lane_en;
        logic [ADDR_BITS-1:0] addr;
    } cmd_t;

    typedef struct packed {
        logic [LANES*LANE_BITS-1:0] data;
        logic [LANES-1:0]           parity;
    } word_t;

endpackage : sram_port_pkg

/* File: tb/ctrl_model.sv */
// Controller-side model that drives the port's pins one cycle at a time
`timescale 1ns/100ps
module ctrl_model (
    input  wire logic                                   mclk_in,
    output logic                                        clock_qualify_n_out,
    output logic                                        chip_select_first_n_out,
    output logic                                        chip_select_second_out,
    output logic                                        chip_select_third_n_out,
    output logic                                        write_n_out,
    output logic [sram_port_pkg::LANES-1:0]             byte_lane_select_n_out,
    output logic                                        burst_advance_or_load_out,
    output logic [sram_port_pkg::ADDR_BITS-1:0]         addr_out,
    output logic                                        sleep_request_out,
    output sram_port_pkg::word_t                        word_out
);

    // Idle, deselected pins from time zero
    initial
    begin
        clock_qualify_n_out = 1'b0;
        {chip_select_first_n_out, chip_select_second_out, chip_select_third_n_out} = 3'h0;
        write_n_out = 1'b1;
        byte_lane_select_n_out = 4'hF;
        burst_advance_or_load_out = 1'b0;
        addr_out = 8'h00;
        sleep_request_out = 1'b0;
        word_out = '0;
    end

    // One cycle of pins, changed 2 ns after the edge and held for the full period.
    // Data lanes carry whatever the caller gives, so idle cycles show changing garbage.
    task automatic put(input logic q_n, input logic [2:0] cs, input logic wr_n, input logic [3:0] bl_n,
                       input logic adv, input logic [7:0] a, input logic sl, input sram_port_pkg::word_t w);
        @(posedge mclk_in);
        #2;
        clock_qualify_n_out = q_n;
        {chip_select_first_n_out, chip_select_second_out, chip_select_third_n_out} = cs;
        write_n_out = wr_n;
        byte_lane_select_n_out = bl_n;
        burst_advance_or_load_out = adv;
        addr_out = a;
        sleep_request_out = sl;
        word_out = w;
    endtask : put

endmodule : ctrl_model

/* File: tb/pipelined_burst_sram_port_test.sv */
// Self-checking bench for the burst static RAM port with a behavioural memory model
`timescale 1ns/100ps
module pipelined_burst_sram_port_test;

    // ****************************************
    // Signals and model state
    // ****************************************
    logic                 mclk_in, rst_in, strap, oe_pin_n, p_q_n, p_cs1_n, p_cs2, p_cs3_n, p_wr_n, p_adv, p_sl;
    logic [3:0]           p_bl_n, parity_lane, bl_n;
    logic [7:0]           p_a, a, b_base;
    logic [31:0]          dq;
    logic                 oe_n, slp, q_n, wr_n, adv, sl, exp_oe, sl_prev, sl_d2, b_valid, b_wr;
    logic [2:0]           cs;
    logic [1:0]           b_cnt;
    logic [4:0]           oe_sh;
    sram_port_pkg::word_t p_w, exp_word;
    sram_port_pkg::word_t mem [256];
    sram_port_pkg::word_t p_word [4];
    logic [7:0]           s_addr [4];
    logic [3:0]           s_bl [4];
    int                   s_kind [4];
    bit                   p_en [4];
    logic                 p_oe [4];
    int                   err_total, total_checks, m, k, o, r;

    ctrl_model u_ctl (
        .mclk_in                   (mclk_in),
        .clock_qualify_n_out       (p_q_n),
        .chip_select_first_n_out   (p_cs1_n),
        .chip_select_second_out    (p_cs2),
        .chip_select_third_n_out   (p_cs3_n),
        .write_n_out               (p_wr_n),
        .byte_lane_select_n_out    (p_bl_n),
        .burst_advance_or_load_out (p_adv),
        .addr_out                  (p_a),
        .sleep_request_out         (p_sl),
        .word_out                  (p_w)
    );

    sram_port u_dut (
        .mclk_in                  (mclk_in),
        .rst_in                   (rst_in),
        .clock_qualify_n_in       (p_q_n),
        .chip_select_first_n_in   (p_cs1_n),
        .chip_select_second_in    (p_cs2),
        .chip_select_third_n_in   (p_cs3_n),
        .write_n_in               (p_wr_n),
        .byte_lane_select_n_in    (p_bl_n),
        .burst_advance_or_load_in (p_adv),
        .addr_in                  (p_a),
        .burst_order_strap_in     (strap),
        .sleep_request_in         (p_sl),
        .output_enable_n_in       (oe_pin_n),
        .data_lane_in             (p_w.data),
        .parity_lane_in           (p_w.parity),
        .data_lane_out            (dq),
        .parity_lane_out          (parity_lane),
        .data_lane_oe_n_out       (oe_n),
        .sleeping_out             (slp)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input bit ok, input string what);
        total_checks++;
        if (!ok)
        begin
            err_total++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    task automatic report_and_stop();
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Reset for two cycles; memory contents survive, so the model keeps its array
    task automatic reset_port();
        rst_in = 1'b1;
        repeat (2) u_ctl.put(1'b0, 3'h0, 1'b1, 4'hF, 1'b0, 8'h00, 1'b0, '0);
        check(oe_n === 1'b1 && slp === 1'b0, "reset state");
        rst_in = 1'b0;
        {m, k, exp_oe, sl_prev, sl_d2, b_valid, oe_sh} = {32'h0, 32'h0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00};
        for (int i = 0; i < 4; i++)
            {s_kind[i], p_en[i]} = {32'h0, 1'b0};
    endtask : reset_port

    // One cycle: mode 0 fills memory, 1 is random traffic, 2 is quiet deselected
    task automatic step(input int mode);
        sram_port_pkg::word_t w;
        int                   kind;
        logic [7:0]           pa;
        w = sram_port_pkg::word_t'({$urandom, 4'($urandom)});
        q_n = (mode == 1) && ($urandom % 6 == 0);
        sl = (mode == 1) && ($urandom % 16 == 0);
        cs = (mode == 2) ? 3'h0 : (mode == 1 && $urandom % 4 == 0) ? 3'($urandom) : 3'h2;
        wr_n = (mode == 1) ? 1'($urandom) : 1'b0;
        bl_n = (mode == 1) ? 4'($urandom) : 4'h0;
        adv = (mode == 1) && ($urandom % 2 == 0);
        a = (mode == 0) ? 8'(k) : 8'($urandom);
        oe_pin_n = (mode == 1) && (k % 97 >= 90);
        pa = a;
        p_en[k % 4] = 1'b0;
        // Stalled or sleeping cycles change nothing in the model
        if (!q_n && !sl)
        begin
            kind = 0;
            if (!adv)
                {b_valid, b_wr, b_base, b_cnt} = {cs == 3'h2, !wr_n, a, 2'h0};
            else if (b_valid)
            begin
                b_cnt = b_cnt + 2'h1;
                a = {b_base[7:2], strap ? (b_base[1:0] ^ b_cnt) : (b_base[1:0] + b_cnt)};
            end
            if (b_valid)
                kind = b_wr ? 2 : 1;
            {s_kind[m % 4], s_addr[m % 4], s_bl[m % 4]} = {kind, a, bl_n};
            o = (m + 2) % 4;
            // Slot two enabled cycles back takes its write data now, in program order
            if (s_kind[o] == 2)
                for (int i = 0; i < 4; i++)
                    if (!s_bl[o][i])
                        {mem[s_addr[o]].data[8 * i +: 8], mem[s_addr[o]].parity[i]} = {w.data[8 * i +: 8], w.parity[i]};
            // Previous enabled command leaves the output registers on this edge
            o = (m + 3) % 4;
            {p_en[k % 4], p_oe[k % 4], p_word[k % 4]} = {1'b1, s_kind[o] != 1, mem[s_addr[o]]};
            m++;
        end
        u_ctl.put(q_n, cs, wr_n, bl_n, adv, adv ? 8'($urandom) : pa, sl, w);
        if (k >= 2 && p_en[(k - 2) % 4])
            {exp_oe, exp_word} = {p_oe[(k - 2) % 4], p_word[(k - 2) % 4]};
        oe_sh = {oe_sh[3:0], oe_pin_n};
        if (oe_sh == 5'h1F)
            check(oe_n === 1'b1, "gated output enable");
        if (oe_sh == 5'h00)
        begin
            check(oe_n === exp_oe, "output enable");
            if (!exp_oe)
                check({dq, parity_lane} === exp_word, "read data");
        end
        check(slp === sl_d2, "sleep status");
        sl_d2 = sl_prev;
        sl_prev = sl;
        k++;
    endtask : step

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    // Hang guard well beyond the planned run length
    initial
    begin
        #400000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        {rst_in, strap, oe_pin_n, err_total, total_checks} = {1'b1, 1'b0, 1'b0, 32'h0, 32'h0};
        r = $urandom(32'h4B0D);
        reset_port();
        repeat (256) step(0);
        repeat (2000) step(1);
        repeat (4) step(2);
        strap = 1'b1;
        reset_port();
        repeat (2000) step(1);
        report_and_stop();
    end

endmodule : pipelined_burst_sram_port_test
